// [include/triple_fifo_map.svh]
`ifndef TRIPLE_FIFO_MAP_SVH
`define TRIPLE_FIFO_MAP_SVH

// FIFO geometry
`define FIFO_DEPTH 12'h800
`define FIFO_LAST_WORD 11'h7ff
`define SERIAL_LAST_BIT 6'h2b
`define PARALLEL_LAST_WORD 2'h3

// Offset presets chosen by the flag-select pins at master reset
`define OFFSET_RESET 11'h040
`define PRESET_FS_111 11'h040
`define PRESET_FS_110 11'h010
`define PRESET_FS_101 11'h008
`define PRESET_FS_011 11'h100
`define PRESET_FS_001 11'h400
`define FS_SERIAL 3'h2
`define FS_PARALLEL 3'h4
`define FS_PARALLEL_IP 3'h0

// Register map (byte addresses)
`define REG_STATUS 12'h000
`define REG_OFFSETS1 12'h004
`define REG_OFFSETS2 12'h008
`define REG_COUNT1 12'h00c
`define REG_CTRL 12'h010

// Control register fields
`define CTRL_LOOP_INHIBIT 0
`define CTRL_FLUSH 1

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [include/triple_fifo_pkg.sv]
package triple_fifo_pkg;

   typedef struct packed {
      logic port_a_select_n;
      logic port_a_write_not_read;
      logic port_a_enable;
      logic port_a_mailbox_select;
   } port_a_ctrl_type;

   typedef struct packed {
      logic port_b_select_n;
      logic port_b_read_enable;
      logic port_b_mailbox_select;
   } port_b_ctrl_type;

   typedef struct packed {
      logic port_c_write_enable;
      logic port_c_mailbox_select;
   } port_c_ctrl_type;

   typedef struct packed {
      logic fifo1_full_or_input_ready;
      logic fifo1_almost_full_n;
      logic fifo1_empty_or_output_ready;
      logic fifo1_almost_empty_n;
      logic fifo2_full_or_input_ready;
      logic fifo2_empty_or_output_ready;
      logic mailbox1_full_n;
      logic mailbox2_full_n;
   } flags_type;

   typedef struct packed {
      logic [31:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [31:0] araddr;
      logic arvalid;
      logic rready;
   } axil_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } axil_resp_type;

   // Gray along reset -> serial programming -> run; parallel programming is two bit flips from run
   typedef enum logic [1:0] {
      PROG_RUN = 2'b00,
      PROG_SERIAL = 2'b01,
      PROG_PARALLEL = 2'b11,
      PROG_SPARE = 2'b10
   } prog_state_type;

endpackage

// [rtl/triple_port_fifo_port_control.sv]
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "triple_fifo_map.svh"

module triple_port_fifo_port_control (
   // Core clock and reset
   input wire logic CORE_CLK_I,
   input wire logic SRST_I,
   // Port A
   input wire logic PORT_A_CLOCK_I,
   input wire triple_fifo_pkg::port_a_ctrl_type PORT_A_CTRL_I,
   input wire logic LOOP_N_I,
   input wire logic [35:0] PORT_A_DATA_I,
   output logic [35:0] PORT_A_DATA_O,
   output logic PORT_A_DATA_OE_O,
   // Port B
   input wire logic PORT_B_CLOCK_I,
   input wire triple_fifo_pkg::port_b_ctrl_type PORT_B_CTRL_I,
   output logic [17:0] PORT_B_DATA_O,
   output logic PORT_B_DATA_OE_O,
   // Port C
   input wire logic PORT_C_CLOCK_I,
   input wire triple_fifo_pkg::port_c_ctrl_type PORT_C_CTRL_I,
   input wire logic [17:0] PORT_C_DATA_I,
   // Reset and configuration pins
   input wire logic FIFO1_MASTER_RESET_N_I,
   input wire logic FIFO2_MASTER_RESET_N_I,
   input wire logic FLAG_SELECT0_SERIAL_DATA_I,
   input wire logic FLAG_SELECT1_SERIAL_ENABLE_N_I,
   input wire logic FLAG_SELECT2_I,
   input wire logic ENDIAN_TIMING_MODE_SELECT_I,
   // Flags
   output triple_fifo_pkg::flags_type FLAGS_O,
   // Register bus
   input wire triple_fifo_pkg::axil_req_type AXI_REQ_I,
   output triple_fifo_pkg::axil_resp_type AXI_RESP_O
);
   import triple_fifo_pkg::*;

   function automatic logic [11:0] occupancy(input logic [11:0] wr, input logic [11:0] rd);
      return wr - rd;
   endfunction

   function automatic logic [10:0] preset_offset(input logic [2:0] fs);
      case (fs)
         3'h7: return `PRESET_FS_111;
         3'h6: return `PRESET_FS_110;
         3'h5: return `PRESET_FS_101;
         3'h3: return `PRESET_FS_011;
         3'h1: return `PRESET_FS_001;
         default: return 11'h000;
      endcase
   endfunction

   logic pa_clk_q, pb_clk_q, pc_clk_q, fifo1_master_reset_n_q, fifo2_master_reset_n_q;
   logic fwft1, fwft2, fwft1_arm, fwft2_arm;
   prog_state_type prog_state;
   logic ip_mode;
   logic [42:0] shift;
   logic [5:0] bit_cnt;
   logic [1:0] word_cnt;
   logic [10:0] x1, y1, x2, y2;
   logic [17:0] mem1 [0:2047];
   logic [17:0] mem2 [0:2047];
   logic [11:0] wp1, rp1, rp1_a, wp1_b1, wp1_b2;
   logic [11:0] wp2, rp2, rp2_c, wp2_a1, wp2_a2;
   logic ffa, afa_n, efb, aeb_n, ffc, efa, mailbox1_full_n_n, mailbox2_full_n_n;
   logic [17:0] mail1, mail2, pa_dout, pb_dout;
   logic pa_oe, pb_oe;
   logic loop_inhibit, flush;
   axil_resp_type axi;
   logic aw_got, w_got;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Port clocks arrive as synchronous levels; act on their rising edge
   wire pa_edge = PORT_A_CLOCK_I & ~pa_clk_q;
   wire pb_edge = PORT_B_CLOCK_I & ~pb_clk_q;
   wire pc_edge = PORT_C_CLOCK_I & ~pc_clk_q;
   wire fifo1_master_reset_n_rise = FIFO1_MASTER_RESET_N_I & ~fifo1_master_reset_n_q;
   wire fifo2_master_reset_n_rise = FIFO2_MASTER_RESET_N_I & ~fifo2_master_reset_n_q;
   // Held through the rise cycle so flags never see a stale programming state
   wire rst1 = SRST_I | ~FIFO1_MASTER_RESET_N_I | ~fifo1_master_reset_n_q | flush;
   wire rst2 = SRST_I | ~FIFO2_MASTER_RESET_N_I | ~fifo2_master_reset_n_q | flush;
   wire [2:0] fs = {FLAG_SELECT2_I, FLAG_SELECT1_SERIAL_ENABLE_N_I, FLAG_SELECT0_SERIAL_DATA_I};

   // Port A decode
   wire a_act = pa_edge & ~PORT_A_CTRL_I.port_a_select_n & PORT_A_CTRL_I.port_a_enable;
   wire a_wr = PORT_A_CTRL_I.port_a_write_not_read;
   wire a_mb = PORT_A_CTRL_I.port_a_mailbox_select;
   wire loop_on = ~LOOP_N_I & ~loop_inhibit & ~a_mb;
   wire loop_sel = a_act & loop_on & (ffa | ~a_wr);
   wire a_rd_sel = (a_act & ~a_wr & ~a_mb & ~LOOP_N_I & loop_inhibit) | (a_act & ~a_wr & ~a_mb & LOOP_N_I) | loop_sel;
   wire a_mail_rd = a_act & ~a_wr & a_mb & ~rst2;
   wire a_mail_wr = a_act & a_wr & a_mb & ~rst1;
   wire a_pin_wr = a_act & a_wr & ~a_mb & ~loop_on & ffa & (prog_state != PROG_PARALLEL);
   wire a_par_wr = a_act & a_wr & ~a_mb & (prog_state == PROG_PARALLEL) & ~rst1;
   wire loop_wr = loop_sel & efa & ffa & ~rst2;
   wire f1_wr = (a_pin_wr | loop_wr) & ~rst1;
   wire [17:0] loop_data = fwft2 ? pa_dout : mem2[rp2[10:0]];
   wire [17:0] f1_data = loop_wr ? loop_data : PORT_A_DATA_I[17:0];
   wire f2_load = pa_edge & ~rst2 & (wp2_a2 != rp2 || !fwft2) &
                  (fwft2 ? ((~efa & ~a_mail_rd) | a_rd_sel) : (a_rd_sel & efa));
   wire [11:0] next_rp2 = f2_load ? rp2 + 12'h001 : rp2;

   // Port B decode
   wire b_act = pb_edge & ~PORT_B_CTRL_I.port_b_select_n & PORT_B_CTRL_I.port_b_read_enable;
   wire b_rd_sel = b_act & ~PORT_B_CTRL_I.port_b_mailbox_select;
   wire b_mail_rd = b_act & PORT_B_CTRL_I.port_b_mailbox_select & ~rst1;
   wire f1_load = pb_edge & ~rst1 & (wp1_b2 != rp1 || !fwft1) &
                  (fwft1 ? ((~efb & ~b_mail_rd) | b_rd_sel) : (b_rd_sel & efb));
   wire [11:0] next_rp1 = f1_load ? rp1 + 12'h001 : rp1;

   // Port C decode
   wire c_act = pc_edge & PORT_C_CTRL_I.port_c_write_enable & ~rst2;
   wire c_f2_wr = c_act & ~PORT_C_CTRL_I.port_c_mailbox_select & ffc;
   wire c_mail_wr = c_act & PORT_C_CTRL_I.port_c_mailbox_select;

   wire [11:0] next_wp1 = f1_wr ? wp1 + 12'h001 : wp1;
   wire [11:0] next_wp2 = c_f2_wr ? wp2 + 12'h001 : wp2;
   wire [10:0] par_value = ip_mode ? {PORT_A_DATA_I[11:9], PORT_A_DATA_I[7:0]} : PORT_A_DATA_I[10:0];
   wire [43:0] serial_word = {shift, FLAG_SELECT0_SERIAL_DATA_I};

   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
      begin
         pa_clk_q <= 1'b0;
         pb_clk_q <= 1'b0;
         pc_clk_q <= 1'b0;
         fifo1_master_reset_n_q <= 1'b0;
         fifo2_master_reset_n_q <= 1'b0;
      end
      else
      begin
         pa_clk_q <= PORT_A_CLOCK_I;
         pb_clk_q <= PORT_B_CLOCK_I;
         pc_clk_q <= PORT_C_CLOCK_I;
         fifo1_master_reset_n_q <= FIFO1_MASTER_RESET_N_I;
         fifo2_master_reset_n_q <= FIFO2_MASTER_RESET_N_I;
      end
   end

   // Timing mode caught at the writing port's first edge after master reset
   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
      begin
         fwft1 <= 1'b0;
         fwft2 <= 1'b0;
         fwft1_arm <= 1'b0;
         fwft2_arm <= 1'b0;
      end
      else
      begin
         if (fifo1_master_reset_n_rise)
            fwft1_arm <= 1'b1;
         else if (pa_edge && fwft1_arm)
         begin
            fwft1 <= ~ENDIAN_TIMING_MODE_SELECT_I;
            fwft1_arm <= 1'b0;
         end
         if (fifo2_master_reset_n_rise)
            fwft2_arm <= 1'b1;
         else if (pc_edge && fwft2_arm)
         begin
            fwft2 <= ~ENDIAN_TIMING_MODE_SELECT_I;
            fwft2_arm <= 1'b0;
         end
      end
   end

   // Offset programming
   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
      begin
         prog_state <= PROG_RUN;
         ip_mode <= 1'b0;
         shift <= 43'h0;
         bit_cnt <= 6'h00;
         word_cnt <= 2'h0;
         x1 <= `OFFSET_RESET;
         y1 <= `OFFSET_RESET;
         x2 <= `OFFSET_RESET;
         y2 <= `OFFSET_RESET;
      end
      else if (fifo1_master_reset_n_rise)
      begin
         bit_cnt <= 6'h00;
         word_cnt <= 2'h0;
         ip_mode <= (fs == `FS_PARALLEL_IP);
         case (fs)
            `FS_SERIAL: prog_state <= PROG_SERIAL;
            `FS_PARALLEL, `FS_PARALLEL_IP: prog_state <= PROG_PARALLEL;
            default:
            begin
               prog_state <= PROG_RUN;
               x1 <= preset_offset(fs);
               y1 <= preset_offset(fs);
            end
         endcase
         if (fifo2_master_reset_n_rise && preset_offset(fs) != 11'h000)
         begin
            x2 <= preset_offset(fs);
            y2 <= preset_offset(fs);
         end
      end
      else if (fifo2_master_reset_n_rise && preset_offset(fs) != 11'h000)
      begin
         x2 <= preset_offset(fs);
         y2 <= preset_offset(fs);
      end
      else
      begin
         case (prog_state)
            PROG_SERIAL:
               if (pa_edge && !FLAG_SELECT1_SERIAL_ENABLE_N_I && !ip_mode)
               begin
                  shift <= serial_word[42:0];
                  bit_cnt <= bit_cnt + 6'h01;
                  if (bit_cnt == `SERIAL_LAST_BIT)
                  begin
                     y1 <= serial_word[43:33];
                     x1 <= serial_word[32:22];
                     y2 <= serial_word[21:11];
                     x2 <= serial_word[10:0];
                     prog_state <= PROG_RUN;
                  end
               end
            PROG_PARALLEL:
               if (a_par_wr)
               begin
                  word_cnt <= word_cnt + 2'h1;
                  case (word_cnt)
                     2'h0: y1 <= par_value;
                     2'h1: x1 <= par_value;
                     2'h2: y2 <= par_value;
                     default: x2 <= par_value;
                  endcase
                  if (word_cnt == `PARALLEL_LAST_WORD)
                     prog_state <= PROG_RUN;
               end
            default: prog_state <= PROG_RUN;
         endcase
      end
   end

   // FIFO1 write side, paced by port A
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst1)
      begin
         wp1 <= 12'h000;
         rp1_a <= 12'h000;
         ffa <= 1'b0;
         afa_n <= 1'b1;
      end
      else if (pa_edge)
      begin
         wp1 <= next_wp1;
         rp1_a <= rp1;
         ffa <= (prog_state != PROG_SERIAL) && (occupancy(next_wp1, rp1_a) != `FIFO_DEPTH);
         afa_n <= occupancy(next_wp1, rp1_a) < (`FIFO_DEPTH - {1'b0, y1});
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (f1_wr)
         mem1[wp1[10:0]] <= f1_data;
   end

   // FIFO1 read side, paced by port B
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst1)
      begin
         rp1 <= 12'h000;
         wp1_b1 <= 12'h000;
         wp1_b2 <= 12'h000;
         efb <= 1'b0;
         aeb_n <= 1'b0;
      end
      else if (pb_edge)
      begin
         wp1_b1 <= wp1;
         wp1_b2 <= wp1_b1;
         rp1 <= next_rp1;
         if (fwft1)
            efb <= f1_load | (efb & ~b_rd_sel);
         else
            efb <= wp1_b1 != next_rp1;
         aeb_n <= occupancy(wp1_b1, next_rp1) > {1'b0, x1};
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
         pb_dout <= 18'h00000;
      else if (f1_load)
         pb_dout <= mem1[rp1[10:0]];
      else if (b_mail_rd)
         pb_dout <= mail1;
   end

   // FIFO2 write side, paced by port C
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst2)
      begin
         wp2 <= 12'h000;
         rp2_c <= 12'h000;
         ffc <= 1'b0;
      end
      else if (pc_edge)
      begin
         wp2 <= next_wp2;
         rp2_c <= rp2;
         ffc <= (prog_state == PROG_RUN) && (occupancy(next_wp2, rp2_c) != `FIFO_DEPTH);
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (c_f2_wr)
         mem2[wp2[10:0]] <= PORT_C_DATA_I;
   end

   // FIFO2 read side, paced by port A
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst2)
      begin
         rp2 <= 12'h000;
         wp2_a1 <= 12'h000;
         wp2_a2 <= 12'h000;
         efa <= 1'b0;
      end
      else if (pa_edge)
      begin
         wp2_a1 <= wp2;
         wp2_a2 <= wp2_a1;
         rp2 <= next_rp2;
         if (fwft2)
            efa <= f2_load | (efa & ~a_rd_sel);
         else
            efa <= wp2_a1 != next_rp2;
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
         pa_dout <= 18'h00000;
      else if (f2_load)
         pa_dout <= mem2[rp2[10:0]];
      else if (a_mail_rd)
         pa_dout <= mail2;
   end

   // Mailboxes: a new write wins over a read on the same edge
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst1)
         mailbox1_full_n_n <= 1'b1;
      else if (a_mail_wr)
         mailbox1_full_n_n <= 1'b0;
      else if (b_mail_rd)
         mailbox1_full_n_n <= 1'b1;
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst2)
         mailbox2_full_n_n <= 1'b1;
      else if (c_mail_wr)
         mailbox2_full_n_n <= 1'b0;
      else if (a_mail_rd)
         mailbox2_full_n_n <= 1'b1;
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
      begin
         mail1 <= 18'h00000;
         mail2 <= 18'h00000;
      end
      else
      begin
         if (a_mail_wr)
            mail1 <= PORT_A_DATA_I[17:0];
         if (c_mail_wr)
            mail2 <= PORT_C_DATA_I;
      end
   end

   // Pin drive enables
   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
      begin
         pa_oe <= 1'b0;
         pb_oe <= 1'b0;
      end
      else
      begin
         pa_oe <= ~PORT_A_CTRL_I.port_a_select_n & ~a_wr;
         pb_oe <= ~PORT_B_CTRL_I.port_b_select_n;
      end
   end

   // Register bus slave: address and data taken in either order
   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
      begin
         axi <= '0;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         loop_inhibit <= 1'b0;
         flush <= 1'b0;
      end
      else
      begin
         flush <= 1'b0;
         axi.awready <= ~axi.awready & AXI_REQ_I.awvalid & ~aw_got & ~axi.bvalid;
         axi.wready <= ~axi.wready & AXI_REQ_I.wvalid & ~w_got & ~axi.bvalid;
         if (axi.awready && AXI_REQ_I.awvalid)
         begin
            aw_got <= 1'b1;
            aw_addr <= AXI_REQ_I.awaddr[11:0];
         end
         if (axi.wready && AXI_REQ_I.wvalid)
         begin
            w_got <= 1'b1;
            w_data <= AXI_REQ_I.wdata;
            w_strb <= AXI_REQ_I.wstrb;
         end
         if (aw_got && w_got && !axi.bvalid)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            axi.bvalid <= 1'b1;
            axi.bresp <= `RESP_OKAY;
            if (aw_addr == `REG_CTRL)
            begin
               if (w_strb[0])
               begin
                  loop_inhibit <= w_data[`CTRL_LOOP_INHIBIT];
                  flush <= w_data[`CTRL_FLUSH];
               end
            end
            else if (aw_addr != `REG_STATUS && aw_addr != `REG_OFFSETS1 &&
                     aw_addr != `REG_OFFSETS2 && aw_addr != `REG_COUNT1)
               axi.bresp <= `RESP_SLVERR;
         end
         else if (axi.bvalid && AXI_REQ_I.bready)
            axi.bvalid <= 1'b0;
         axi.arready <= ~axi.arready & AXI_REQ_I.arvalid & ~axi.rvalid;
         if (axi.arready && AXI_REQ_I.arvalid)
         begin
            axi.rvalid <= 1'b1;
            axi.rresp <= `RESP_OKAY;
            case (AXI_REQ_I.araddr[11:0])
               `REG_STATUS: axi.rdata <= {19'h0, prog_state, ip_mode, fwft2, fwft1, mailbox2_full_n_n, mailbox1_full_n_n,
                                          efa, ffc, aeb_n, efb, afa_n, ffa};
               `REG_OFFSETS1: axi.rdata <= {5'h0, y1, 5'h0, x1};
               `REG_OFFSETS2: axi.rdata <= {5'h0, y2, 5'h0, x2};
               `REG_COUNT1: axi.rdata <= {20'h0, occupancy(wp1, rp1)};
               `REG_CTRL: axi.rdata <= {31'h0, loop_inhibit};
               default:
               begin
                  axi.rdata <= 32'h00000000;
                  axi.rresp <= `RESP_SLVERR;
               end
            endcase
         end
         else if (axi.rvalid && AXI_REQ_I.rready)
            axi.rvalid <= 1'b0;
      end
   end

   assign AXI_RESP_O = axi;
   assign PORT_A_DATA_O = {18'h00000, pa_dout};
   assign PORT_A_DATA_OE_O = pa_oe;
   assign PORT_B_DATA_O = pb_dout;
   assign PORT_B_DATA_OE_O = pb_oe;
   assign FLAGS_O = '{ffa, afa_n, efb, aeb_n, ffc, efa, mailbox1_full_n_n, mailbox2_full_n_n};

   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (SRST_I);

   a_porta_drive_gate: assert property (pa_oe |-> $past(!PORT_A_CTRL_I.port_a_select_n && !a_wr))
      else $error("port A driven while deselected or writing");
   a_fifo1_write_step: assert property (f1_wr |=> wp1 == $past(wp1) + 12'h001)
      else $error("FIFO1 write pointer did not advance");
   a_fifo2_read_ready: assert property (f2_load && !fwft2 |-> efa)
      else $error("FIFO2 read while empty");
   a_mail2_read_clear: assert property (a_mail_rd && !c_mail_wr |=> mailbox2_full_n_n && pa_dout == $past(mail2))
      else $error("mailbox 2 read wrong");
   a_portb_drive_gate: assert property (PORT_B_CTRL_I.port_b_select_n |=> !pb_oe)
      else $error("port B driven while deselected");
   a_mail1_read_clear: assert property (b_mail_rd && !a_mail_wr |=> mailbox1_full_n_n)
      else $error("mailbox 1 flag not cleared");
   a_mail2_write_set: assert property (c_mail_wr |=> !mailbox2_full_n_n && mail2 == $past(PORT_C_DATA_I))
      else $error("mailbox 2 write lost");
   a_std_read_step: assert property (!fwft1 && f1_load |=> rp1 == $past(rp1) + 12'h001)
      else $error("FIFO1 read pointer did not advance");
   a_serial_hold_full: assert property (prog_state == PROG_SERIAL |-> !ffa)
      else $error("port A input ready during serial load");
   a_loop_needs_room: assert property (loop_wr |-> ffa && efa)
      else $error("loop transfer while FIFO1 full or FIFO2 empty");
   a_fifo1_full_flag: assert property (pa_edge && !rst1 && occupancy(next_wp1, rp1_a) == `FIFO_DEPTH |=> !ffa)
      else $error("FIFO1 full not flagged");

   c_serial_done: cover property (prog_state == PROG_SERIAL ##1 prog_state == PROG_RUN);
   c_loop_transfer: cover property (loop_wr);
   c_mail_round: cover property (c_mail_wr ##[1:20] a_mail_rd);
   c_fifo1_full: cover property (!ffa && prog_state == PROG_RUN && !rst1);

endmodule

// [dv/port_partner.sv]
`timescale 1ns/1ps
module port_partner (
   // Core timing
   input wire logic clk_i,
   input wire logic rst_i,
   // Far-side pins
   output logic [2:0] pclk_o,
   output logic mrs_n_o,
   output logic mode_o
);
   int cnt;
   // Unrelated port rates so edges drift apart
   always_ff @(posedge clk_i)
   begin
      cnt <= rst_i ? 0 : cnt + 1;
      pclk_o[0] <= (cnt % 4) >= 2;
      pclk_o[1] <= (cnt % 6) >= 3;
      pclk_o[2] <= (cnt % 10) >= 5;
      mrs_n_o <= !rst_i && cnt > 20;
      mode_o <= 1'b1;
   end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import triple_fifo_pkg::*;
   logic clk = 0;
   logic rst = 1;
   logic [2:0] pclk;
   logic mrs_n, mode, aoe, boe;
   port_a_ctrl_type a = 4'h8;
   port_b_ctrl_type b = 3'h4;
   port_c_ctrl_type c = '0;
   logic [35:0] ad = '0;
   logic [35:0] ao, m;
   logic [17:0] bo;
   logic [17:0] cd = '0;
   flags_type fl;
   axil_req_type q = '0;
   axil_resp_type r;
   logic [31:0] lf = 32'h6ba3;
   logic [31:0] v;
   logic [1:0] s;
   logic mr = 1;
   logic fm = 1;
   logic [2:0] fsel = 3'h7;
   logic [43:0] sw;
   int failures = 0;
   int checked = 0;
   always #2 clk = ~clk;
   port_partner p (.clk_i(clk), .rst_i(rst), .pclk_o(pclk), .mrs_n_o(mrs_n), .mode_o(mode));
   triple_port_fifo_port_control uut (.CORE_CLK_I(clk), .SRST_I(rst), .PORT_A_CLOCK_I(pclk[0]),
      .PORT_A_CTRL_I(a), .LOOP_N_I(1'b1), .PORT_A_DATA_I(ad), .PORT_A_DATA_O(ao), .PORT_A_DATA_OE_O(aoe),
      .PORT_B_CLOCK_I(pclk[1]), .PORT_B_CTRL_I(b), .PORT_B_DATA_O(bo), .PORT_B_DATA_OE_O(boe),
      .PORT_C_CLOCK_I(pclk[2]), .PORT_C_CTRL_I(c), .PORT_C_DATA_I(cd), .FIFO1_MASTER_RESET_N_I(mrs_n & mr),
      .FIFO2_MASTER_RESET_N_I(mrs_n & mr), .FLAG_SELECT0_SERIAL_DATA_I(fsel[0]),
      .FLAG_SELECT1_SERIAL_ENABLE_N_I(fsel[1]), .FLAG_SELECT2_I(fsel[2]),
      .ENDIAN_TIMING_MODE_SELECT_I(mode & fm), .FLAGS_O(fl), .AXI_REQ_I(q), .AXI_RESP_O(r));
   // Offsets kept inside the legal range
   function logic [10:0] off(input logic [8:0] x);
      return {2'b01, x};
   endfunction
   function logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task chk(input string n, input logic [35:0] e, input logic [35:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Counts edges the design takes: sampled 1 after sampled 0
   task pe(input int i, input int k);
      logic l;
      repeat (k)
      begin
         @(posedge clk);
         l = pclk[i];
         do
         begin
            l = pclk[i];
            @(posedge clk);
         end
         while (!(pclk[i] && !l));
      end
   endtask
   task drv(input int i, input logic [3:0] x, input logic [35:0] d);
      case (i)
         0:
         begin
            a <= x;
            ad <= d;
         end
         1: b <= x[2:0];
         default: begin c <= x[1:0]; cd <= d[17:0]; end
      endcase
   endtask
   task op(input int i, input logic [3:0] x, input logic [35:0] d);
      pe(i, 1);
      drv(i, x, d);
      pe(i, 1);
      drv(i, i == 2 ? 4'h0 : 4'h8 >> i, 36'h0);
      #1;
   endtask
   task rd(input logic [31:0] ra, output logic [31:0] d, output logic [1:0] e);
      @(posedge clk);
      q.araddr <= ra;
      q.arvalid <= 1'b1;
      q.rready <= 1'b1;
      do @(posedge clk); while (!r.arready);
      q.arvalid <= 1'b0;
      while (!r.rvalid) @(posedge clk);
      d = r.rdata;
      e = r.rresp;
      q.rready <= 1'b0;
   endtask
   task wr(input logic [31:0] wa, input logic [31:0] d);
      @(posedge clk);
      {q.awaddr, q.wdata, q.wstrb, q.awvalid, q.wvalid, q.bready} <= {wa, d, 4'hf, 3'h7};
      do
      begin
         @(posedge clk);
         if (r.awready) q.awvalid <= 1'b0;
         if (r.wready) q.wvalid <= 1'b0;
      end
      while (!r.bvalid);
      q.bready <= 1'b0;
   endtask
   task end_sim;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #20000;
      failures++;
      end_sim;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (60) @(posedge clk);
      chk("flags", 36'hcb, {28'h0, fl});
      rd(32'h0, v, s);
      chk("status", 36'hd3, {4'h0, v});
      rd(32'h14, v, s);
      chk("unmapped", 36'h2, {34'h0, s});
      wr(32'h10, 32'h1);
      rd(32'h10, v, s);
      chk("ctrl", 36'h1, {4'h0, v});
      lf = nxt(lf);
      op(2, 4'h3, {18'h0, lf[17:0]});
      chk("mailbox2_full_n", 36'h0, {35'h0, fl.mailbox2_full_n});
      op(0, 4'h3, 36'h0);
      chk("mail2", {18'h0, lf[17:0]}, ao);
      chk("mailbox2_full_n read", 36'h1, {35'h0, fl.mailbox2_full_n});
      chk("a oe", 36'h1, {35'h0, aoe});
      lf = nxt(lf);
      m = {lf[3:0], lf};
      op(0, 4'h7, m);
      chk("mailbox1_full_n", 36'h0, {35'h0, fl.mailbox1_full_n});
      op(1, 4'h3, 36'h0);
      chk("mail1", {18'h0, m[17:0]}, {18'h0, bo});
      chk("b oe", 36'h1, {35'h0, boe});
      lf = nxt(lf);
      op(0, 4'h6, {lf[3:0], lf});
      pe(1, 2);
      #1;
      chk("efb", 36'h1, {35'h0, fl.fifo1_empty_or_output_ready});
      chk("b hold", {18'h0, m[17:0]}, {18'h0, bo});
      op(1, 4'h2, 36'h0);
      chk("fifo1", {18'h0, lf[17:0]}, {18'h0, bo});
      lf = nxt(lf);
      op(2, 4'h2, {18'h0, lf[17:0]});
      pe(0, 2);
      op(0, 4'h2, 36'h0);
      chk("fifo2", {18'h0, lf[17:0]}, ao);
      @(posedge clk);
      a <= 4'h4;
      repeat (3) @(posedge clk);
      #1;
      chk("a oe off", 36'h0, {35'h0, aoe});
      chk("b oe off", 36'h0, {35'h0, boe});
      lf = nxt(lf);
      sw = {off(lf[8:0]), off(lf[17:9]), off(lf[26:18]), off(lf[31:23])};
      @(posedge clk);
      {mr, fm, fsel} <= {2'b00, 3'h2};
      repeat (4) @(posedge clk);
      mr <= 1'b1;
      for (int k = 43; k >= 0; k--)
      begin
         pe(0, 1);
         fsel <= {2'b00, sw[k]};
      end
      #1;
      chk("ffa serial", 36'h0, {35'h0, fl.fifo1_full_or_input_ready});
      pe(0, 1);
      fsel <= 3'h7;
      pe(0, 1);
      #1;
      chk("ffa loaded", 36'h1, {35'h0, fl.fifo1_full_or_input_ready});
      pe(2, 1);
      #1;
      chk("ffc loaded", 36'h1, {35'h0, fl.fifo2_full_or_input_ready});
      rd(32'h4, v, s);
      chk("offsets1", {9'h0, sw[43:33], 5'h0, sw[32:22]}, {4'h0, v});
      rd(32'h8, v, s);
      chk("offsets2", {9'h0, sw[21:11], 5'h0, sw[10:0]}, {4'h0, v});
      lf = nxt(lf);
      op(0, 4'h6, {18'h0, lf[17:0]});
      pe(1, 2);
      #1;
      chk("orb early", 36'h0, {35'h0, fl.fifo1_empty_or_output_ready});
      pe(1, 1);
      #1;
      chk("orb", 36'h1, {35'h0, fl.fifo1_empty_or_output_ready});
      chk("fall through", {18'h0, lf[17:0]}, {18'h0, bo});
      rd(32'hc, v, s);
      chk("count1", 36'h0, {4'h0, v});
      end_sim;
   end
endmodule
